// >>> design/ext_code_bus.v
// external code bus control: fetch strobe, code source latch, wait stretch,
// bus configuration / timing / segment registers behind an apb slave
// assumes all inputs synchronous to clock and a cpu request handshake
//
// Notes on behaviour
// - fetch strobe low only for external fetches
// - latch code source pin at reset release
// - latched zero sends every fetch external
// - latched one: internal up to limit
// - pin becomes wait input after reset
// - wait high stretches cycle until low
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ext_bus_consts.vh"

module ext_code_bus
(
  // clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // cpu access request
  input  wire        req_valid,
  input  wire        req_fetch,
  input  wire [19:0] req_addr,
  output wire        req_ready,
  output wire        req_internal,
  output wire        req_err,
  // external bus pins
  input  wire        code_source_select,
  output reg         program_fetch_strobe_n,
  output reg         ext_cycle_active
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function [2:0] reg_sel;
    input [31:0] a;
    begin
      reg_sel = 3'h7;
      if (a[1:0] == 2'h0)
      begin
        case (a[13:2])
          `IDX_DATA_SEGMENT    : reg_sel = 3'h0;
          `IDX_EXTRA_SEGMENT   : reg_sel = 3'h1;
          `IDX_CODE_SEGMENT    : reg_sel = 3'h2;
          `IDX_BUS_TIMING_LOW  : reg_sel = 3'h3;
          `IDX_BUS_TIMING_HIGH : reg_sel = 3'h4;
          `IDX_BUS_CONFIG      : reg_sel = 3'h5;
          `IDX_BUS_STATUS      : reg_sel = 3'h6;
          default              : reg_sel = 3'h7;
        endcase
        if (a[31:14] != 18'h0)
          reg_sel = 3'h7;
      end
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_EXT  = 1'b1;

  reg  [7:0] data_segment_r;
  reg  [7:0] extra_segment_r;
  reg  [7:0] code_segment_r;
  reg  [7:0] bus_timing_low_r;
  reg  [7:0] bus_timing_high_r;
  reg  [7:0] bus_configuration_r;
  reg        code_src_r;
  reg        armed_r;
  reg        state_r;
  reg        state_nxt;
  reg  [1:0] cnt_r;
  reg  [1:0] cnt_nxt;
  reg        fetch_r;

  wire [2:0] sel      = reg_sel(paddr);
  wire       wr_en    = psel & penable & pwrite;
  wire       setup    = psel & ~penable;
  wire       wait_dis = bus_configuration_r[`BCR_WAIT_DIS_BIT];
  wire       bus_dis  = bus_configuration_r[`BCR_BUS_DIS_BIT];

  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped or status write
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ((sel == 3'h7) | (pwrite & (sel == 3'h6)));

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      data_segment_r      <= `RST_SEGMENT;
      extra_segment_r     <= `RST_SEGMENT;
      code_segment_r      <= `RST_SEGMENT;
      bus_timing_low_r    <= `RST_BUS_TIMING_LOW;
      bus_timing_high_r   <= `RST_BUS_TIMING_HIGH;
      bus_configuration_r <= `RST_BUS_CONFIG;
    end
    else if (wr_en)
    begin
      case (sel)
        3'h0    : data_segment_r      <= pwdata[7:0];
        3'h1    : extra_segment_r     <= pwdata[7:0];
        3'h2    : code_segment_r      <= pwdata[7:0];
        3'h3    : bus_timing_low_r    <= pwdata[7:0];
        3'h4    : bus_timing_high_r   <= pwdata[7:0];
        3'h5    : bus_configuration_r <= pwdata[7:0];
        default : ;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
      prdata <= 32'h0;
    else if (setup)
    begin
      case (sel)
        3'h0    : prdata <= {24'h0, data_segment_r};
        3'h1    : prdata <= {24'h0, extra_segment_r};
        3'h2    : prdata <= {24'h0, code_segment_r};
        3'h3    : prdata <= {24'h0, bus_timing_low_r};
        3'h4    : prdata <= {24'h0, bus_timing_high_r};
        3'h5    : prdata <= {24'h0, bus_configuration_r};
        3'h6    : prdata <= {30'h0, ext_cycle_active, code_src_r};
        default : prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // code source latch at first clock after reset release
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      armed_r    <= 1'b0;
      code_src_r <= 1'b0;
    end
    else if (!armed_r)
    begin
      armed_r    <= 1'b1;
      code_src_r <= code_source_select;
    end
  end

  // ----------------------------------------------------------------
  // access routing
  // ----------------------------------------------------------------
  // internal only for fetches, latched one, address within limit
  assign req_internal = req_fetch & code_src_r & (req_addr <= `INT_CODE_LIMIT);
  wire   ext_req      = req_valid & armed_r & ~req_internal & (state_r == ST_IDLE);

  // after release the pin is only read as a wait request
  wire   wait_req     = armed_r & code_source_select & ~wait_dis;

  wire   ext_done     = (state_r == ST_EXT) & (cnt_r == 2'd0) & ~wait_req;

  assign req_err   = req_valid & armed_r & ~req_internal & bus_dis & (state_r == ST_IDLE);
  assign req_ready = (req_valid & armed_r & req_internal & (state_r == ST_IDLE))
                   | req_err | ext_done;

  // ----------------------------------------------------------------
  // external cycle sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE :
      begin
        if (ext_req & ~bus_dis)
        begin
          state_nxt = ST_EXT;
          cnt_nxt   = `EXT_MIN_CYCLES - 2'd1;
        end
      end
      ST_EXT :
      begin
        if (cnt_r != 2'd0)
          cnt_nxt = cnt_r - 2'd1;
        else if (!wait_req)
          state_nxt = ST_IDLE;
      end
      default :
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_r                <= ST_IDLE;
      cnt_r                  <= 2'd0;
      fetch_r                <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      ext_cycle_active       <= 1'b0;
    end
    else
    begin
      state_r          <= state_nxt;
      cnt_r            <= cnt_nxt;
      ext_cycle_active <= (state_nxt == ST_EXT);
      if (state_r == ST_IDLE)
        fetch_r <= req_fetch;
      // strobe low only while an external fetch cycle runs
      if (state_nxt == ST_EXT)
        program_fetch_strobe_n <= (state_r == ST_IDLE) ? ~req_fetch : ~fetch_r;
      else
        program_fetch_strobe_n <= 1'b1;
    end
  end

endmodule

// >>> include/ext_bus_consts.vh
// constants for the external code bus control block
// assumes inclusion by bare name from design files
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

// register indexes; byte address is four times the index
`define IDX_DATA_SEGMENT     12'h441
`define IDX_EXTRA_SEGMENT    12'h442
`define IDX_CODE_SEGMENT     12'h443
`define IDX_BUS_TIMING_LOW   12'h468
`define IDX_BUS_TIMING_HIGH  12'h469
`define IDX_BUS_CONFIG       12'h46a
`define IDX_BUS_STATUS       12'h46b

// reset values
`define RST_SEGMENT          8'h00
`define RST_BUS_TIMING_LOW   8'hef
`define RST_BUS_TIMING_HIGH  8'hff
`define RST_BUS_CONFIG       8'h07

// bus configuration fields
`define BCR_WAIT_DIS_BIT     4
`define BCR_BUS_DIS_BIT      3

// bus status fields
`define STAT_CODE_SRC_BIT    0
`define STAT_BUSY_BIT        1

// last internal code address (32 kbyte on chip)
`define INT_CODE_LIMIT       20'h07fff

// least number of clocks an external access lasts
`define EXT_MIN_CYCLES       2'd2

`endif

// >>> testbench/ext_code_bus_sva.sv
// assertions for the external code bus control block
// assumes bcr wait disable stays clear while requests run
`timescale 1ns/1ps
module ext_code_bus_sva
(
  // clock and reset
  input wire        clock,
  input wire        rst_b,
  // cpu request and external pins
  input wire        req_valid,
  input wire        req_fetch,
  input wire [19:0] req_addr,
  input wire        req_ready,
  input wire        req_internal,
  input wire        req_err,
  input wire        code_source_select,
  input wire        program_fetch_strobe_n,
  input wire        ext_cycle_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  reg first_r;
  reg src_r;
  // copy of the code source level taken at the first edge out of reset
  always @(posedge clock)
  begin
    first_r <= !rst_b;
    if (rst_b && first_r)
      src_r <= code_source_select;
  end
  sequence ext_start;
    !ext_cycle_active ##1 ext_cycle_active;
  endsequence
  AST_STROBE: assert property (program_fetch_strobe_n == !(ext_cycle_active && req_fetch))
    else $error("fetch strobe wrong");
  AST_CYCLE_END: assert property (req_ready && ext_cycle_active |=> !ext_cycle_active)
    else $error("external cycle overran");
  AST_EXT_ONLY: assert property (req_ready && req_fetch && !src_r |-> !req_internal)
    else $error("internal fetch in external mode");
  AST_INT_LIMIT: assert property (req_ready && req_fetch && src_r && !req_err
    |-> req_internal == (req_addr <= 20'h07fff))
    else $error("internal limit wrong");
  AST_WAIT_HOLD: assert property (ext_cycle_active && code_source_select |-> !req_ready)
    else $error("wait ignored");
  AST_WAIT_END: assert property (ext_cycle_active && $past(ext_cycle_active)
    && !code_source_select |-> req_ready)
    else $error("cycle not ended after wait");
  AST_EXT_BOUND: assert property (ext_start |-> ##[1:20] req_ready)
    else $error("external cycle never ended");
endmodule

bind ext_code_bus ext_code_bus_sva i_sva (.clock(clock), .rst_b(rst_b),
  .req_valid(req_valid), .req_fetch(req_fetch), .req_addr(req_addr),
  .req_ready(req_ready), .req_internal(req_internal), .req_err(req_err),
  .code_source_select(code_source_select), .ext_cycle_active(ext_cycle_active),
  .program_fetch_strobe_n(program_fetch_strobe_n));

// >>> testbench/ext_code_bus_tb.sv
// self-checking bench for the external code bus control block
// assumes the design, its checker and the memory model
`timescale 1ns/1ps
module ext_code_bus_tb;
  reg clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  reg req_valid = 0, req_fetch = 0, boot = 1, boot_lvl = 0, er, lo, int_s, err_s;
  reg [31:0] paddr = 0, pwdata = 0, rd;
  reg [19:0] req_addr = 0;
  reg [3:0] wait_cycles = 0;
  wire pready, pslverr, req_ready, req_internal, req_err, strobe_n, active, wait_req;
  wire [31:0] prdata;
  wire pin = boot ? boot_lvl : wait_req;
  integer fail_count = 0, comparisons = 0, cyc, i;
  localparam [71:0] IX = {12'h441, 12'h442, 12'h443, 12'h468, 12'h469, 12'h46a};
  localparam [47:0] RV = {8'h00, 8'h00, 8'h00, 8'hef, 8'hff, 8'h07};
  always #2 clock = ~clock;
  ext_code_bus i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .req_valid(req_valid), .req_fetch(req_fetch), .req_addr(req_addr),
    .req_ready(req_ready), .req_internal(req_internal), .req_err(req_err),
    .code_source_select(pin), .program_fetch_strobe_n(strobe_n), .ext_cycle_active(active));
  ext_mem_model i_mem (.clock(clock), .ext_cycle_active(active),
    .wait_cycles(wait_cycles), .wait_req(wait_req));
  task give_verdict;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input c, input [127:0] m);
    begin
      comparisons = comparisons + 1;
      if (!c)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t %0s", $time, m);
      end
      if (m == "hang")
        give_verdict;
    end
  endtask
  task apb(input w, input [11:0] idx, input [31:0] wd);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {18'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      cyc = 0;
      @(posedge clock);
      while (pready !== 1'b1 && cyc < 20)
      begin
        @(posedge clock);
        cyc = cyc + 1;
      end
      if (cyc == 20)
        chk(0, "hang");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task req(input f, input [19:0] a);
    begin
      @(posedge clock);
      req_valid <= 1'b1;
      req_fetch <= f;
      req_addr <= a;
      cyc = 0;
      lo = 0;
      while (req_ready !== 1'b1 && cyc < 30)
      begin
        @(negedge clock);
        cyc = cyc + 1;
        lo = lo | !strobe_n;
      end
      if (cyc == 30)
        chk(0, "hang");
      int_s = req_internal;
      err_s = req_err;
      @(posedge clock);
      req_valid <= 1'b0;
    end
  endtask
  task do_reset(input lvl);
    begin
      boot <= 1'b1;
      boot_lvl <= lvl;
      rst_b <= 1'b0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      boot <= 1'b0;
    end
  endtask
  task t_regs;
    for (i = 0; i < 6; i = i + 1)
    begin
      apb(0, IX[12*i +: 12], 0);
      chk(rd === {24'h0, RV[8*i +: 8]} && er === 1'b0, "reset value");
      apb(1, IX[12*i +: 12], 32'h5a);
      apb(0, IX[12*i +: 12], 0);
      chk(rd === 32'h5a, "readback");
      apb(1, IX[12*i +: 12], {24'h0, RV[8*i +: 8]});
      apb(0, 12'h444, 0);
      chk(er === 1'b1, "unmapped");
    end
  endtask
  task t_src0;
    begin
      req(1, 20'h00100);
      chk(cyc == 3 && lo && int_s === 1'b0, "external fetch");
      req(0, 20'h00200);
      chk(cyc == 3 && !lo, "data access");
      wait_cycles <= 4'h3;
      req(1, 20'h00300);
      chk(cyc == 6 && lo, "wait stretch");
      wait_cycles <= 4'h0;
      apb(0, 12'h46b, 0);
      chk(rd[0] === 1'b0, "latched source");
      apb(1, 12'h46a, 32'h0f);
      req(0, 20'h00005);
      chk(cyc == 1 && err_s === 1'b1 && !lo, "bus disabled");
      apb(1, 12'h46a, 32'h07);
    end
  endtask
  task t_src1;
    begin
      do_reset(1'b1);
      req(1, 20'h07fff);
      chk(cyc == 1 && int_s === 1'b1 && !lo, "internal fetch");
      req(1, 20'h08000);
      chk(cyc == 3 && int_s === 1'b0 && lo, "above limit");
    end
  endtask
  initial
  begin
    do_reset(1'b0);
    t_regs;
    t_src0;
    t_src1;
    give_verdict;
  end
endmodule

// >>> testbench/ext_mem_model.sv
// external memory that asks for wait cycles on each access
// assumes ext_cycle_active marks the external cycle
`timescale 1ns/1ps
module ext_mem_model
(
  input  wire       clock,
  input  wire       ext_cycle_active,
  input  wire [3:0] wait_cycles,
  output wire       wait_req
);
  reg [3:0] cnt_r;
  always @(posedge clock)
    cnt_r <= ext_cycle_active ? cnt_r + 4'h1 : 4'h0;
  // wait held high for the first wait_cycles clocks after the start cycle
  assign wait_req = ext_cycle_active && cnt_r != 4'h0 && cnt_r <= wait_cycles;
endmodule
